/* File: src/ttc_defs.vh */
// Constants for the three channel interval timer
`ifndef TTC_DEFS_VH
`define TTC_DEFS_VH
`define TTC_SEL_HI    7
`define TTC_SEL_LO    6
`define TTC_ACC_HI    5
`define TTC_ACC_LO    4
`define TTC_MODE_HI   3
`define TTC_MODE_LO   1
`define TTC_BCD_BIT   0
`define TTC_ADDR_CW   2'h3
`define TTC_SEL_BAD   2'h3
`define TTC_ACC_LATCH 2'h0
`define TTC_ACC_LSB   2'h1
`define TTC_ACC_MSB   2'h2
`define TTC_ACC_BOTH  2'h3
`define TTC_MODE0     3'h0
`define TTC_MODE1     3'h1
`define TTC_MODE2     3'h2
`define TTC_MODE3     3'h3
`define TTC_MODE4     3'h4
`define TTC_MODE5     3'h5
`define TTC_CNT_ZERO  16'h0000
`define TTC_CNT_ONE   16'h0001
`define TTC_CNT_TWO   16'h0002
`define TTC_BCD_MAX   16'h9999
`define TTC_BIN_FULL  17'h10000
`define TTC_BCD_FULL  17'h02710
`define TTC_PH_ZERO   17'h00000
`define TTC_PH_ONE    17'h00001
`define TTC_BYTE_ZERO 8'h00
`define TTC_NIB_ZERO  4'h0
`define TTC_NIB_NINE  4'h9
`endif

/* File: src/ttc_sync.v */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module ttc_sync #(
  parameter             W       = 1,
  parameter [W-1:0]     RST_VAL = {W{1'b0}}
) (
  input  wire         mclk,
  input  wire         rst_b,
  input  wire [W-1:0] pin_in,
  output reg  [W-1:0] sync_out
);
  reg [W-1:0] meta_q;

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q   <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q   <= pin_in;
      sync_out <= meta_q;
    end
  end
endmodule // ttc_sync
`default_nettype wire

/* File: src/ttc_dec.v */
// Binary or BCD decrement and binary value of a loaded count
`timescale 1ns/10ps
`default_nettype none
`include "ttc_defs.vh"
module ttc_dec (
  input  wire [15:0] value,
  input  wire        bcd,
  output reg  [15:0] dec,
  output reg  [16:0] bin
);
  integer k;
  reg     borrow;

  // Weighted digit value; zero count stands for a full wrap
  function [16:0] digit_w;
    input [3:0]  d;
    input [16:0] w;
    begin
      digit_w = d * w;
    end
  endfunction

  always @* begin
    dec    = value;
    borrow = 1'b1;
    bin    = `TTC_PH_ZERO;
    if (bcd) begin
      for (k = 0; k < 4; k = k + 1) begin
        if (borrow) begin
          if (value[k*4 +: 4] == `TTC_NIB_ZERO) begin
            dec[k*4 +: 4] = `TTC_NIB_NINE;
          end else begin
            dec[k*4 +: 4] = value[k*4 +: 4] - 4'h1;
            borrow        = 1'b0;
          end
        end
      end
      bin = digit_w(value[15:12], 17'h003E8) + digit_w(value[11:8], 17'h00064)
          + digit_w(value[7:4], 17'h0000A) + digit_w(value[3:0], 17'h00001);
      if (value == `TTC_CNT_ZERO) begin
        bin = `TTC_BCD_FULL;
      end
    end else begin
      dec = value - `TTC_CNT_ONE;
      bin = (value == `TTC_CNT_ZERO) ? `TTC_BIN_FULL : {1'b0, value};
    end
  end
endmodule // ttc_dec
`default_nettype wire

/* File: src/ttc_top.v */
// Three channel interval timer with parallel processor port
`timescale 1ns/10ps
`default_nettype none
`include "ttc_defs.vh"
// Behaviour
// - Address 11 write goes to control word
// - Bits 7:6 counter select; bit0 BCD
// - Bits 5:4 latch, LSB, MSB or both
// - Bits 3:1 mode, bit3 ignored modes 2,3
// - Counter events on counter clock falling edge
// - Mode 0 output low, high at terminal
// - Mode 0 reload halts, restarts after second
// - Mode 0 gate low suspends counting
// - Mode 1 trigger drives low until terminal
// - Mode 1 new count waits next trigger
// - Mode 1 retrigger restarts full count
// - Mode 2 divides, one clock low pulse
// - Mode 2 reload applies next period
// - Mode 2 gate low forces output high
// - Mode 3 square wave, odd high longer
// - Mode 3 reload used after next transition
// - Mode 3 gate low holds high, restart
// - Mode 4 high, count, one clock strobe
// - Mode 4 loading holds high, stops count
// - Mode 4 gate low resets full count
// - Mode 5 counts after load and trigger
// - Mode 5 retrigger restarts count sequence
// - Three independent sixteen bit down counters
// - Addresses 0 to 2 reach counters
// - Chip select high ignores bus, floats
module ttc_top (
  input  wire       mclk,
  input  wire       rst_b,
  input  wire       cs_b,
  input  wire       rd_b,
  input  wire       wr_b,
  input  wire       port_select_hi,
  input  wire       port_select_lo,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg        data_oe_b,
  input  wire [2:0] cnt_clk,
  input  wire [2:0] cnt_gate,
  output reg  [2:0] cnt_out
);
  localparam NCH = 3;

  // Every pin except rst_b crosses two flip-flops before any logic reads it
  wire [2:0] strobe_s;
  wire [9:0] bus_s;
  wire [2:0] clk_s;
  wire [2:0] gate_s;

  ttc_sync #(.W(3), .RST_VAL(3'h7)) u_sync_strobe (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .pin_in   ({cs_b, rd_b, wr_b}),
    .sync_out (strobe_s)
  );

  ttc_sync #(.W(16), .RST_VAL(16'h0000)) u_sync_misc (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .pin_in   ({port_select_hi, port_select_lo, data_in, cnt_clk, cnt_gate}),
    .sync_out ({bus_s, clk_s, gate_s})
  );

  wire       cs_s   = ~strobe_s[2];
  wire       rd_s   = ~strobe_s[1];
  wire       wr_s   = ~strobe_s[0];
  wire [1:0] addr_s = bus_s[9:8];
  wire [7:0] din_s  = bus_s[7:0];

  // Per-channel state
  reg [2:0]  mode_q   [0:NCH-1];
  reg [1:0]  acc_q    [0:NCH-1];
  reg        bcd_q    [0:NCH-1];
  reg [15:0] cr_q     [0:NCH-1];
  reg [7:0]  cr_lo_q  [0:NCH-1];
  reg [15:0] ce_q     [0:NCH-1];
  reg [15:0] ol_q     [0:NCH-1];
  reg [16:0] ph_q     [0:NCH-1];
  reg [NCH-1:0] latched_q;
  reg [NCH-1:0] wptr_q;
  reg [NCH-1:0] rptr_q;
  reg [NCH-1:0] armed_q;
  reg [NCH-1:0] load_q;
  reg [NCH-1:0] halt_q;
  reg [NCH-1:0] crv_q;
  reg [NCH-1:0] trig_q;
  reg [NCH-1:0] clk_prev_q;
  reg [NCH-1:0] gate_prev_q;

  // Bus capture
  reg        wr_prev_q;
  reg        rd_prev_q;
  reg        wcap_v_q;
  reg [1:0]  wcap_a_q;
  reg [7:0]  wcap_d_q;
  reg        rcap_v_q;
  reg [1:0]  rcap_a_q;

  wire [47:0] dec_w;
  wire [50:0] bin_w;
  wire [50:0] hi_w;
  wire [50:0] lo_w;
  wire [47:0] ce_flat;
  wire [47:0] cr_flat;
  wire [2:0]  bcd_flat;

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      assign ce_flat[g*16 +: 16] = ce_q[g];
      assign cr_flat[g*16 +: 16] = cr_q[g];
      assign bcd_flat[g]         = bcd_q[g];
      ttc_dec u_dec (
        .value (ce_flat[g*16 +: 16]),
        .bcd   (bcd_flat[g]),
        .dec   (dec_w[g*16 +: 16]),
        .bin   ()
      );
      ttc_dec u_bin (
        .value (cr_flat[g*16 +: 16]),
        .bcd   (bcd_flat[g]),
        .dec   (),
        .bin   (bin_w[g*17 +: 17])
      );
      // Odd counts give the extra clock to the high half
      assign lo_w[g*17 +: 17] = {1'b0, bin_w[g*17+1 +: 16]};
      assign hi_w[g*17 +: 17] = bin_w[g*17 +: 17] - lo_w[g*17 +: 17];
    end
  endgenerate

  // Mode field with bit 3 ignored for modes 2 and 3
  function [2:0] mode_of;
    input [2:0] m;
    begin
      if (m[1]) begin
        mode_of = {1'b0, m[1:0]};
      end else begin
        mode_of = m;
      end
    end
  endfunction

  // Byte presented on a read for the access order and pointer
  function [7:0] byte_of;
    input [15:0] v;
    input [1:0]  acc;
    input        ptr;
    begin
      if (acc == `TTC_ACC_MSB || (acc == `TTC_ACC_BOTH && ptr)) begin
        byte_of = v[15:8];
      end else begin
        byte_of = v[7:0];
      end
    end
  endfunction

  wire wr_done = wr_prev_q & ~wr_s & wcap_v_q;
  wire rd_done = rd_prev_q & ~rd_s & rcap_v_q;
  wire rd_act  = cs_s & rd_s & (addr_s != `TTC_ADDR_CW);
  wire [1:0] cw_sel = wcap_d_q[`TTC_SEL_HI:`TTC_SEL_LO];
  wire [1:0] cw_acc = wcap_d_q[`TTC_ACC_HI:`TTC_ACC_LO];

  integer i;
  integer j;
  wire [2:0] cf_v  = clk_prev_q & ~clk_s;
  wire [2:0] trg_v = trig_q | (~gate_prev_q & gate_s);

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < NCH; i = i + 1) begin
        mode_q[i]  <= `TTC_MODE0;
        acc_q[i]   <= `TTC_ACC_BOTH;
        bcd_q[i]   <= 1'b0;
        cr_q[i]    <= `TTC_CNT_ZERO;
        cr_lo_q[i] <= `TTC_BYTE_ZERO;
        ce_q[i]    <= `TTC_CNT_ZERO;
        ol_q[i]    <= `TTC_CNT_ZERO;
        ph_q[i]    <= `TTC_PH_ZERO;
      end
      latched_q   <= 3'h0;
      wptr_q      <= 3'h0;
      rptr_q      <= 3'h0;
      armed_q     <= 3'h0;
      load_q      <= 3'h0;
      halt_q      <= 3'h0;
      crv_q       <= 3'h0;
      trig_q      <= 3'h0;
      clk_prev_q  <= 3'h0;
      gate_prev_q <= 3'h0;
      cnt_out     <= 3'h0;
    end else begin
      clk_prev_q  <= clk_s;
      gate_prev_q <= gate_s;
      for (i = 0; i < NCH; i = i + 1) begin
        trig_q[i] <= cf_v[i] ? 1'b0 : trg_v[i];
        if (cf_v[i]) begin
          case (mode_q[i])
            `TTC_MODE0: begin
              if (load_q[i]) begin
                ce_q[i]    <= cr_q[i];
                load_q[i]  <= 1'b0;
                armed_q[i] <= 1'b1;
              end else if (armed_q[i] && !halt_q[i] && gate_s[i]) begin
                ce_q[i] <= dec_w[i*16 +: 16];
                if (ce_q[i] == `TTC_CNT_ONE) begin
                  cnt_out[i] <= 1'b1;
                end
              end
            end
            `TTC_MODE1: begin
              if (trg_v[i] && crv_q[i]) begin
                ce_q[i]    <= cr_q[i];
                armed_q[i] <= 1'b1;
                cnt_out[i] <= 1'b0;
              end else if (armed_q[i]) begin
                ce_q[i] <= dec_w[i*16 +: 16];
                if (ce_q[i] == `TTC_CNT_ONE) begin
                  cnt_out[i] <= 1'b1;
                  armed_q[i] <= 1'b0;
                end
              end
            end
            `TTC_MODE2: begin
              if (!gate_s[i]) begin
                cnt_out[i] <= 1'b1;
                load_q[i]  <= crv_q[i];
              end else if (load_q[i]) begin
                ce_q[i]    <= cr_q[i];
                armed_q[i] <= 1'b1;
                load_q[i]  <= 1'b0;
                cnt_out[i] <= 1'b1;
              end else if (armed_q[i]) begin
                if (ce_q[i] == `TTC_CNT_TWO) begin
                  ce_q[i]    <= `TTC_CNT_ONE;
                  cnt_out[i] <= 1'b0;
                end else if (ce_q[i] == `TTC_CNT_ONE) begin
                  ce_q[i]    <= cr_q[i];
                  cnt_out[i] <= 1'b1;
                end else begin
                  ce_q[i] <= dec_w[i*16 +: 16];
                end
              end
            end
            `TTC_MODE3: begin
              if (!gate_s[i]) begin
                cnt_out[i] <= 1'b1;
                load_q[i]  <= crv_q[i];
              end else if (load_q[i]) begin
                ce_q[i]    <= cr_q[i];
                ph_q[i]    <= hi_w[i*17 +: 17];
                armed_q[i] <= 1'b1;
                load_q[i]  <= 1'b0;
                cnt_out[i] <= 1'b1;
              end else if (armed_q[i]) begin
                ce_q[i] <= dec_w[i*16 +: 16];
                ph_q[i] <= ph_q[i] - `TTC_PH_ONE;
                if (ph_q[i] == `TTC_PH_ONE) begin
                  if (cnt_out[i] && lo_w[i*17 +: 17] != `TTC_PH_ZERO) begin
                    cnt_out[i] <= 1'b0;
                    ph_q[i]    <= lo_w[i*17 +: 17];
                  end else begin
                    cnt_out[i] <= 1'b1;
                    ce_q[i]    <= cr_q[i];
                    ph_q[i]    <= hi_w[i*17 +: 17];
                  end
                end
              end
            end
            `TTC_MODE4: begin
              cnt_out[i] <= 1'b1;
              if (halt_q[i]) begin
                cnt_out[i] <= 1'b1;
              end else if (!gate_s[i]) begin
                load_q[i]  <= crv_q[i];
                armed_q[i] <= 1'b0;
              end else if (load_q[i]) begin
                ce_q[i]    <= cr_q[i];
                armed_q[i] <= 1'b1;
                load_q[i]  <= 1'b0;
              end else if (armed_q[i]) begin
                ce_q[i] <= dec_w[i*16 +: 16];
                if (ce_q[i] == `TTC_CNT_ONE) begin
                  cnt_out[i] <= 1'b0;
                  armed_q[i] <= 1'b0;
                end
              end
            end
            default: begin
              cnt_out[i] <= 1'b1;
              if (trg_v[i] && crv_q[i]) begin
                ce_q[i]    <= cr_q[i];
                armed_q[i] <= 1'b1;
              end else if (armed_q[i]) begin
                ce_q[i] <= dec_w[i*16 +: 16];
                if (ce_q[i] == `TTC_CNT_ONE) begin
                  cnt_out[i] <= 1'b0;
                  armed_q[i] <= 1'b0;
                end
              end
            end
          endcase
        end

        // Bus writes override clock events in the same cycle
        if (wr_done && wcap_a_q == `TTC_ADDR_CW && cw_sel == i) begin
          if (cw_acc == `TTC_ACC_LATCH) begin
            if (!latched_q[i]) begin
              ol_q[i]      <= ce_q[i];
              latched_q[i] <= 1'b1;
            end
          end else begin
            mode_q[i]    <= mode_of(wcap_d_q[`TTC_MODE_HI:`TTC_MODE_LO]);
            acc_q[i]     <= cw_acc;
            bcd_q[i]     <= wcap_d_q[`TTC_BCD_BIT];
            wptr_q[i]    <= 1'b0;
            rptr_q[i]    <= 1'b0;
            latched_q[i] <= 1'b0;
            armed_q[i]   <= 1'b0;
            load_q[i]    <= 1'b0;
            halt_q[i]    <= 1'b0;
            crv_q[i]     <= 1'b0;
            // Mode 0 starts low, all others idle high
            cnt_out[i]   <= (mode_of(wcap_d_q[`TTC_MODE_HI:`TTC_MODE_LO])
                             != `TTC_MODE0);
          end
        end
        if (wr_done && wcap_a_q == i) begin
          if (acc_q[i] == `TTC_ACC_BOTH && !wptr_q[i]) begin
            cr_lo_q[i] <= wcap_d_q;
            wptr_q[i]  <= 1'b1;
            if (mode_q[i] == `TTC_MODE0 || mode_q[i] == `TTC_MODE4) begin
              halt_q[i] <= 1'b1;
            end
          end else begin
            wptr_q[i] <= 1'b0;
            halt_q[i] <= 1'b0;
            crv_q[i]  <= 1'b1;
            if (acc_q[i] == `TTC_ACC_LSB) begin
              cr_q[i] <= {`TTC_BYTE_ZERO, wcap_d_q};
            end else if (acc_q[i] == `TTC_ACC_MSB) begin
              cr_q[i] <= {wcap_d_q, `TTC_BYTE_ZERO};
            end else begin
              cr_q[i] <= {wcap_d_q, cr_lo_q[i]};
            end
            // One-shot and strobe on trigger keep the count for the
            // next trigger; mode 2 picks it up at period end, mode 3 at the next output transition
            if (mode_q[i] == `TTC_MODE0) begin
              load_q[i]  <= 1'b1;
              armed_q[i] <= 1'b0;
              cnt_out[i] <= 1'b0;
            end else if (mode_q[i] == `TTC_MODE4) begin
              load_q[i]  <= 1'b1;
              armed_q[i] <= 1'b0;
            end else if (mode_q[i] == `TTC_MODE2 ||
                         mode_q[i] == `TTC_MODE3) begin
              if (!armed_q[i]) begin
                load_q[i] <= 1'b1;
              end
            end
          end
        end
        if (rd_done && rcap_a_q == i) begin
          if (acc_q[i] == `TTC_ACC_BOTH) begin
            rptr_q[i] <= ~rptr_q[i];
          end
          if (acc_q[i] != `TTC_ACC_BOTH || rptr_q[i]) begin
            latched_q[i] <= 1'b0;
          end
        end
      end
    end
  end

  // Bus front end; nothing is taken while chip select is high
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
      wcap_v_q  <= 1'b0;
      wcap_a_q  <= 2'h0;
      wcap_d_q  <= `TTC_BYTE_ZERO;
      rcap_v_q  <= 1'b0;
      rcap_a_q  <= 2'h0;
      data_out  <= `TTC_BYTE_ZERO;
      data_oe_b <= 1'b1;
    end else begin
      wr_prev_q <= wr_s;
      rd_prev_q <= rd_s;
      if (wr_s && cs_s) begin
        wcap_v_q <= 1'b1;
        wcap_a_q <= addr_s;
        wcap_d_q <= din_s;
      end else if (!wr_s) begin
        wcap_v_q <= 1'b0;
      end
      if (rd_act) begin
        rcap_v_q <= 1'b1;
        rcap_a_q <= addr_s;
      end else if (!rd_s) begin
        rcap_v_q <= 1'b0;
      end
      data_oe_b <= ~rd_act;
      // Address 3 reads are a no-operation; bus stays floating
      // Byte taken once at strobe start and held, so a live count
      // cannot move under the host's sampling point
      if (!rd_act) begin
        data_out <= `TTC_BYTE_ZERO;
      end else if (data_oe_b) begin
        for (j = 0; j < NCH; j = j + 1) begin
          if (addr_s == j) begin
            data_out <= byte_of(latched_q[j] ? ol_q[j] : ce_q[j],
                                acc_q[j], rptr_q[j]);
          end
        end
      end
    end
  end
endmodule // ttc_top
`default_nettype wire

/* File: bench/ttc_top_checker.sv */
// Concurrent checks on the timer bus port and counter outputs
`timescale 1ns/10ps
`default_nettype none
module ttc_top_checker (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       cs_b,
  input wire logic       rd_b,
  input wire logic       wr_b,
  input wire logic       port_select_hi,
  input wire logic       port_select_lo,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe_b,
  input wire logic [2:0] cnt_clk,
  input wire logic [2:0] cnt_gate,
  input wire logic [2:0] cnt_out
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Writes and gate moves may change outputs off the clock, so mask them
  logic [3:0] calm_q;
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      calm_q <= 4'h0;
    end else if (!wr_b || cnt_gate != $past(cnt_gate)) begin
      calm_q <= 4'h0;
    end else if (calm_q != 4'hF) begin
      calm_q <= calm_q + 4'h1;
    end
  end
  property p_cs_idle;
    cs_b [*5] |-> data_oe_b && data_out == 8'h00;
  endproperty
  a_cs_idle: assert property (p_cs_idle)
    else $error("bus driven while deselected");
  property p_cw_float;
    (!cs_b && !rd_b && port_select_hi && port_select_lo) [*5] |-> data_oe_b;
  endproperty
  a_cw_float: assert property (p_cw_float)
    else $error("read of control address drove the bus");
  property p_rd_answer;
    $fell(rd_b) && !cs_b && !(port_select_hi && port_select_lo)
      |-> ##[1:5] !data_oe_b;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("counter read not answered");
  property p_rd_release;
    $rose(rd_b) |-> ##[1:5] data_oe_b;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("bus not released after read");
  property p_rd_stable;
    !rd_b && !$past(rd_b) && !data_oe_b && !$past(data_oe_b)
      |-> $stable(data_out);
  endproperty
  a_rd_stable: assert property (p_rd_stable)
    else $error("read data moved during strobe");
  property p_wr_quiet;
    (!wr_b) [*5] |-> data_oe_b;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("bus driven during write");
  property p_reset_state;
    $rose(rst_b) |-> data_oe_b && cnt_out == 3'h0;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("wrong state after reset");
  property p_clk_edge;
    calm_q >= 4'h8 |-> ((cnt_out ^ $past(cnt_out)) & $past(cnt_clk, 2)) == 3'h0;
  endproperty
  a_clk_edge: assert property (p_clk_edge)
    else $error("output changed away from a clock fall");
endmodule // ttc_top_checker
bind ttc_top ttc_top_checker u_chk (
  .mclk(mclk), .rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b),
  .port_select_hi(port_select_hi), .port_select_lo(port_select_lo),
  .data_in(data_in), .data_out(data_out), .data_oe_b(data_oe_b),
  .cnt_clk(cnt_clk), .cnt_gate(cnt_gate), .cnt_out(cnt_out)
);
`default_nettype wire

/* File: bench/ttc_host_model.sv */
// Processor bus master model for the timer port
`timescale 1ns/10ps
`default_nettype none
module ttc_host_model (
  input  wire logic       mclk,
  output var  logic       cs_b,
  output var  logic       rd_b,
  output var  logic       wr_b,
  output var  logic       port_select_hi,
  output var  logic       port_select_lo,
  output var  logic [7:0] data_in,
  input  wire logic [7:0] data_out
);
  initial begin
    cs_b = 1'b1;
    rd_b = 1'b1;
    wr_b = 1'b1;
    {port_select_hi, port_select_lo} = 2'h0;
    data_in = 8'h00;
  end
  // Strobe held 5 edges, then 5 edges of recovery; ends at a falling edge
  task automatic xfer(input logic sel_b, input logic wr, input logic [1:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    cs_b <= sel_b;
    {port_select_hi, port_select_lo} <= a;
    data_in <= wr ? d : ~data_in;
    rd_b <= wr;
    wr_b <= ~wr;
    repeat (4) @(posedge mclk);
    // Read data taken mid-cycle, where it has settled
    @(negedge mclk);
    q = data_out;
    @(posedge mclk);
    cs_b <= 1'b1;
    rd_b <= 1'b1;
    wr_b <= 1'b1;
    // Released bus must not keep showing the last byte
    data_in <= ~d;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
  endtask
endmodule // ttc_host_model
`default_nettype wire

/* File: bench/ttc_top_tb.sv */
// Self-checking testbench for the three channel interval timer
`timescale 1ns/10ps
`default_nettype none
module ttc_top_tb;
  localparam int PER = 8; // Counter clock period in mclk cycles
  logic            mclk     = 1'b0;
  logic            rst_b    = 1'b0;
  logic [2:0]      cnt_clk  = 3'h0;
  logic [2:0]      cnt_gate = 3'h7;
  wire logic       cs_b;
  wire logic       rd_b;
  wire logic       wr_b;
  wire logic       ps_hi;
  wire logic       ps_lo;
  wire logic [7:0] d_in;
  wire logic [7:0] d_out;
  wire logic       oe_b;
  wire logic [2:0] cnt_out;
  int              err_count = 0;
  int              checks    = 0;
  int              tick      = 0;
  int              n;
  logic [7:0]      rb;
  logic [15:0]     v;
  logic [15:0]     w;
  logic [2:0]      o;
  always #25 mclk = ~mclk;
  // Counter clocks run free, 4 mclk high and 4 low
  always @(posedge mclk) begin
    tick <= tick + 1;
    if (tick % 4 == 3) begin
      cnt_clk <= ~cnt_clk;
    end
  end
  ttc_top u_dut (
    .mclk(mclk), .rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b),
    .port_select_hi(ps_hi), .port_select_lo(ps_lo), .data_in(d_in),
    .data_out(d_out), .data_oe_b(oe_b), .cnt_clk(cnt_clk),
    .cnt_gate(cnt_gate), .cnt_out(cnt_out)
  );
  ttc_host_model u_host (
    .mclk(mclk), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b),
    .port_select_hi(ps_hi), .port_select_lo(ps_lo), .data_in(d_in),
    .data_out(d_out)
  );
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_host.xfer(1'b0, 1'b1, a, d, q);
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] q);
    u_host.xfer(1'b0, 1'b0, a, 8'h00, q);
  endtask
  task automatic cw(input logic [1:0] ch, input logic [1:0] acc,
                    input logic [2:0] m, input logic bcd);
    wr(2'h3, {ch, acc, m, bcd});
  endtask
  task automatic load(input logic [1:0] ch, input logic [15:0] cnt);
    wr(ch, cnt[7:0]);
    wr(ch, cnt[15:8]);
  endtask
  task automatic latch_rd(input logic [1:0] ch, output logic [15:0] q);
    logic [7:0] lo;
    logic [7:0] hi;
    cw(ch, 2'h0, 3'h0, 1'b0);
    rd(ch, lo);
    rd(ch, hi);
    q = {hi, lo};
  endtask
  // Gate low across at least one clock fall, then high: a trigger
  task automatic trig(input int ch);
    @(posedge mclk);
    cnt_gate[ch] <= 1'b0;
    repeat (2 * PER) @(posedge mclk);
    cnt_gate[ch] <= 1'b1;
  endtask
  // Length in mclk cycles of the next whole stretch at level lvl
  task automatic width(input int ch, input logic lvl, output int cnt);
    int i;
    for (i = 0; i < 4000 && cnt_out[ch] === lvl; i++) @(negedge mclk);
    for (i = 0; i < 4000 && cnt_out[ch] !== lvl; i++) @(negedge mclk);
    for (cnt = 0; cnt < 4000 && cnt_out[ch] === lvl; cnt++) @(negedge mclk);
    if (cnt == 4000 || i == 4000) begin
      err_count++;
      $display("[ERR] %0t output %0d stuck", $time, ch);
      finish_test;
    end
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    chk(16'(oe_b), 16'h0001);
    chk(16'(cnt_out), 16'h0000);
    rd(2'h3, rb);
    chk(16'(rb), 16'h0000);
    u_host.xfer(1'b1, 1'b0, 2'h0, 8'h00, rb);
    chk(16'(rb), 16'h0000);
    $display("test bus refusals done");
    cw(2'h0, 2'h3, 3'h4, 1'b0);
    chk(16'(cnt_out[0]), 16'h0001);
    cw(2'h0, 2'h3, 3'h0, 1'b0);
    chk(16'(cnt_out[0]), 16'h0000);
    load(2'h0, 16'h0028);
    repeat (3 * PER) @(negedge mclk);
    @(posedge mclk);
    cnt_gate[0] <= 1'b0;
    repeat (2 * PER) @(negedge mclk);
    latch_rd(2'h0, v);
    // Deselected write must not touch the frozen count
    u_host.xfer(1'b1, 1'b1, 2'h0, 8'h01, rb);
    repeat (3 * PER) @(negedge mclk);
    latch_rd(2'h0, w);
    chk(w, v);
    chk(16'(v < 16'h0028 && v > 16'h0019), 16'h0001);
    @(posedge mclk);
    cnt_gate[0] <= 1'b1;
    // Bounded even if the captured count is above 16'h0028
    repeat ((v > 16'h0028 ? 37 : v - 3) * PER) @(negedge mclk);
    chk(16'(cnt_out[0]), 16'h0000);
    repeat (6 * PER) @(negedge mclk);
    chk(16'(cnt_out[0]), 16'h0001);
    wr(2'h0, 8'h05);
    chk(16'(cnt_out[0]), 16'h0001);
    wr(2'h0, 8'h00);
    chk(16'(cnt_out[0]), 16'h0000);
    $display("test mode 0 done");
    cw(2'h1, 2'h3, 3'h7, 1'b0);
    for (int k = 4; k < 6; k++) begin
      load(2'h1, 16'(k));
      width(1, 1'b1, n);
      width(1, 1'b1, n);
      chk(16'(n), 16'((k + 1) / 2 * PER));
      width(1, 1'b0, n);
      chk(16'(n), 16'(k / 2 * PER));
    end
    $display("test mode 3 done");
    cw(2'h2, 2'h1, 3'h2, 1'b0);
    wr(2'h2, 8'h04);
    width(2, 1'b0, n);
    chk(16'(n), 16'(PER));
    width(2, 1'b1, n);
    chk(16'(n), 16'(3 * PER));
    @(posedge mclk);
    cnt_gate[2] <= 1'b0;
    repeat (PER) @(negedge mclk);
    n = 0;
    repeat (5 * PER) begin
      @(negedge mclk);
      n += int'(cnt_out[2] !== 1'b1);
    end
    chk(16'(n), 16'h0000);
    $display("test mode 2 done");
    cw(2'h1, 2'h3, 3'h1, 1'b0);
    wr(2'h1, 8'h09);
    cw(2'h1, 2'h3, 3'h1, 1'b0);
    load(2'h1, 16'h0003);
    trig(1);
    width(1, 1'b0, n);
    chk(16'(n), 16'(3 * PER));
    cw(2'h2, 2'h3, 3'h5, 1'b0);
    load(2'h2, 16'h0003);
    repeat (6 * PER) @(negedge mclk);
    chk(16'(cnt_out[2]), 16'h0001);
    trig(2);
    width(2, 1'b0, n);
    chk(16'(n), 16'(PER));
    cw(2'h0, 2'h3, 3'h4, 1'b0);
    load(2'h0, 16'h0003);
    width(0, 1'b0, n);
    chk(16'(n), 16'(PER));
    $display("test modes 1 4 5 done");
    o = cnt_out;
    cw(2'h3, 2'h3, 3'h0, 1'b0);
    chk(16'(cnt_out), 16'(o));
    cw(2'h1, 2'h3, 3'h0, 1'b1);
    load(2'h1, 16'h0100);
    repeat (3 * PER) @(negedge mclk);
    latch_rd(2'h1, v);
    chk({4'h0, v[15:4]}, 16'h0009);
    $display("test select and decimal done");
    finish_test;
  end
endmodule // ttc_top_tb
`default_nettype wire
